// file: verilog/autoneg_adv_pkg.sv
// Constants and types shared by the advertisement register logic
package autoneg_adv_pkg;

  // Register geometry
  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 5;
  localparam logic [4:0] ADV_ADDR = 5'h04;

  // Field positions inside the advertisement word
  localparam int NEXT_PAGE_BIT = 15;
  localparam int RSV14_BIT = 14;
  localparam int REMOTE_FAULT_BIT = 13;
  localparam int RSV_HI = 12;
  localparam int RSV_LO = 10;
  localparam int T4_BIT = 9;
  localparam int TAF_HI = 8;
  localparam int TAF_LO = 5;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 0;

  // Values after reset and after the default load
  localparam logic NEXT_PAGE_RESET = 1'b0;
  localparam logic RSV14_RESET = 1'b0;
  localparam logic [2:0] RSV12_10_RESET = 3'h0;
  localparam logic [3:0] TAF_AN_DEFAULT = 4'hf;
  localparam logic [4:0] SEL_DEFAULT = 5'h01;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Full capability set reported in the status register
  localparam logic [3:0] STATUS_CAPS = 4'hf;

  // Cycles spent in init so the mode pin synchroniser settles
  localparam logic [1:0] INIT_CYCLES = 2'h2;

  // Negotiation phases
  typedef enum logic [1:0] {
    PH_INIT,
    PH_IDLE,
    PH_NEG
  } phase_e;

endpackage : autoneg_adv_pkg

// file: verilog/adv_word_latch.sv
// Holds the link code word handed to the link pulse logic
`timescale 1ns/1ps
module adv_word_latch (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [15:0] word_in,
  input wire logic remote_fault,
  output logic [15:0] word_out
);

  typedef struct packed {
    logic [15:0] word;
  } latch_state_s;

  latch_state_s s;
  latch_state_s next_s;

  // Word snapshots only on load; fault bit tracks live
  always_comb
  begin
    next_s = s;
    if (load)
    begin
      next_s.word = word_in;
    end
    next_s.word[autoneg_adv_pkg::REMOTE_FAULT_BIT] = remote_fault;
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s <= autoneg_adv_pkg::WORD_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign word_out = s.word;

endmodule : adv_word_latch

// file: verilog/autoneg_advertisement_register.sv
// Auto-negotiation advertisement register with link code word source
//
// Summary of operation
// - Next-page flag advertised to partner as stored.
// - Next-page flag resets to zero.
// - Reserved bit fourteen reads as zero.
// - Bit fourteen writable only with override set.
// - Reserved twelve to ten writable only with override.
// - Local link fault sets remote-fault bit.
// - No local fault clears remote-fault bit.
// - Remote-fault bit carried in code word only while negotiating.
// - Reserved twelve to ten read as zero.
// - Ability bits tell partner supported technologies.
// - 100Base-T4 ability bit always reads zero.
// - Ability bits override-gated, defaults from mode pin.
// - Negotiation off: idle, speed/duplex from selects.
// - Negotiation on: abilities default to all ones.
// - Status capability bits report everything from the first clock after reset.
// - Selector field sent from bits four to zero.
`timescale 1ns/1ps
module autoneg_advertisement_register (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic cmd_override,
  input wire logic autoneg_enable,
  input wire logic an_restart,
  input wire logic rate_select,
  input wire logic duplex_select,
  input wire logic local_link_fault,
  input wire logic hardware_software_mode_pin,
  output logic [15:0] link_code_word,
  output logic an_active,
  output logic send_idle,
  output logic speed_100,
  output logic full_duplex,
  output logic [3:0] status_caps
);

  typedef struct packed {
    logic [1:0] hwsw_sync;
    autoneg_adv_pkg::phase_e phase;
    logic [1:0] init_cnt;
    logic next_page;
    logic rsv14;
    logic remote_fault;
    logic [2:0] rsv12_10;
    logic [3:0] technology_ability_field;
    logic [4:0] selector;
    logic [15:0] rdata;
    logic rdata_valid;
    logic load_word;
    logic an_active;
    logic send_idle;
    logic speed_100;
    logic full_duplex;
    logic [3:0] status_caps;
  } adv_state_s;

  adv_state_s s;
  adv_state_s next_s;
  logic reg_hit;
  logic [15:0] read_image;
  logic [15:0] adv_word;
  logic [3:0] fixed_mode_taf;

  assign reg_hit = (reg_addr == autoneg_adv_pkg::ADV_ADDR);

  // Software view: reserved and T4 positions forced low
  always_comb
  begin
    read_image = 16'h0000;
    read_image[autoneg_adv_pkg::NEXT_PAGE_BIT] = s.next_page;
    read_image[autoneg_adv_pkg::RSV14_BIT] = 1'b0;
    read_image[autoneg_adv_pkg::REMOTE_FAULT_BIT] = s.remote_fault;
    read_image[autoneg_adv_pkg::RSV_HI:autoneg_adv_pkg::RSV_LO] = 3'h0;
    read_image[autoneg_adv_pkg::T4_BIT] = 1'b0;
    read_image[autoneg_adv_pkg::TAF_HI:autoneg_adv_pkg::TAF_LO] = s.technology_ability_field;
    read_image[autoneg_adv_pkg::SEL_HI:autoneg_adv_pkg::SEL_LO] = s.selector;
  end

  // Partner view: stored reserved bits go out, T4 never does
  always_comb
  begin
    adv_word = 16'h0000;
    adv_word[autoneg_adv_pkg::NEXT_PAGE_BIT] = s.next_page;
    adv_word[autoneg_adv_pkg::RSV14_BIT] = s.rsv14;
    adv_word[autoneg_adv_pkg::RSV_HI:autoneg_adv_pkg::RSV_LO] = s.rsv12_10;
    adv_word[autoneg_adv_pkg::TAF_HI:autoneg_adv_pkg::TAF_LO] = s.technology_ability_field;
    adv_word[autoneg_adv_pkg::SEL_HI:autoneg_adv_pkg::SEL_LO] = s.selector;
  end

  // Forced-mode default: only the strapped speed/duplex is advertised
  always_comb
  begin
    fixed_mode_taf = 4'h0;
    fixed_mode_taf[{rate_select, duplex_select}] = 1'b1;
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_s = s;
    // First stage feeds only the second stage
    next_s.hwsw_sync = {s.hwsw_sync[0], hardware_software_mode_pin};
    next_s.rdata_valid = 1'b0;
    next_s.load_word = 1'b0;
    next_s.status_caps = autoneg_adv_pkg::STATUS_CAPS;
    next_s.remote_fault = local_link_fault;
    case (s.phase)
      autoneg_adv_pkg::PH_INIT:
      begin
        next_s.send_idle = 1'b0;
        next_s.an_active = 1'b0;
        if (s.init_cnt == autoneg_adv_pkg::INIT_CYCLES)
        begin
          // Defaults wait for the settled mode pin
          next_s.rsv14 = autoneg_adv_pkg::RSV14_RESET;
          next_s.rsv12_10 = autoneg_adv_pkg::RSV12_10_RESET;
          next_s.selector = autoneg_adv_pkg::SEL_DEFAULT;
          if (autoneg_enable || !s.hwsw_sync[1])
          begin
            next_s.technology_ability_field = autoneg_adv_pkg::TAF_AN_DEFAULT;
          end
          else
          begin
            next_s.technology_ability_field = fixed_mode_taf;
          end
          if (autoneg_enable)
          begin
            next_s.phase = autoneg_adv_pkg::PH_NEG;
            next_s.load_word = 1'b1;
          end
          else
          begin
            next_s.phase = autoneg_adv_pkg::PH_IDLE;
          end
        end
        else
        begin
          next_s.init_cnt = s.init_cnt + 2'h1;
        end
      end
      autoneg_adv_pkg::PH_IDLE:
      begin
        // Forced mode: no negotiation, idles on the line
        next_s.send_idle = 1'b1;
        next_s.an_active = 1'b0;
        next_s.speed_100 = rate_select;
        next_s.full_duplex = duplex_select;
        if (autoneg_enable)
        begin
          next_s.phase = autoneg_adv_pkg::PH_NEG;
          next_s.load_word = 1'b1;
        end
      end
      autoneg_adv_pkg::PH_NEG:
      begin
        next_s.send_idle = 1'b0;
        next_s.an_active = 1'b1;
        if (!autoneg_enable)
        begin
          next_s.phase = autoneg_adv_pkg::PH_IDLE;
        end
        else if (an_restart)
        begin
          // Mid-negotiation edits wait for this point
          next_s.load_word = 1'b1;
        end
      end
      default:
      begin
        next_s.phase = autoneg_adv_pkg::PH_INIT;
      end
    endcase
    // Writes during init would be lost to the default load
    if (reg_wr && reg_hit && s.phase != autoneg_adv_pkg::PH_INIT)
    begin
      next_s.next_page = reg_wdata[autoneg_adv_pkg::NEXT_PAGE_BIT];
      if (cmd_override)
      begin
        next_s.rsv14 = reg_wdata[autoneg_adv_pkg::RSV14_BIT];
        next_s.rsv12_10 = reg_wdata[autoneg_adv_pkg::RSV_HI:autoneg_adv_pkg::RSV_LO];
        next_s.technology_ability_field =
          reg_wdata[autoneg_adv_pkg::TAF_HI:autoneg_adv_pkg::TAF_LO];
        next_s.selector = reg_wdata[autoneg_adv_pkg::SEL_HI:autoneg_adv_pkg::SEL_LO];
      end
    end
    // Read answers one cycle later from the current image
    if (reg_rd && reg_hit)
    begin
      next_s.rdata = read_image;
      next_s.rdata_valid = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Code word holder; fault only reaches partner while negotiating
  adv_word_latch u_word (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(s.load_word),
    .word_in(adv_word),
    .remote_fault(s.remote_fault && s.an_active),
    .word_out(link_code_word)
  );

  assign reg_rdata = s.rdata;
  assign reg_rdata_valid = s.rdata_valid;
  assign an_active = s.an_active;
  assign send_idle = s.send_idle;
  assign speed_100 = s.speed_100;
  assign full_duplex = s.full_duplex;
  assign status_caps = s.status_caps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Writes that the override must block
  sequence seq_gated_write;
    reg_wr && reg_hit && !cmd_override && s.phase != autoneg_adv_pkg::PH_INIT;
  endsequence

  // Restart request followed by the load strobe
  sequence seq_restart;
    (s.phase == autoneg_adv_pkg::PH_NEG && autoneg_enable && an_restart) ##1 s.load_word;
  endsequence

  // Init completing with negotiation enabled
  sequence seq_init_an;
    (s.phase == autoneg_adv_pkg::PH_INIT && s.init_cnt == autoneg_adv_pkg::INIT_CYCLES
      && autoneg_enable && !reg_wr) ##1 (s.phase == autoneg_adv_pkg::PH_NEG);
  endsequence

  a_next_page_sent: assert property (
    s.load_word |=> link_code_word[15] == $past(s.next_page))
    else $error("next page not carried into code word");

  a_next_page_reset: assert property (
    $fell(srst) |-> !s.next_page && !link_code_word[15])
    else $error("next page not zero after reset");

  a_rsv14_read_zero: assert property (
    reg_rdata_valid |-> !reg_rdata[14])
    else $error("reserved bit fourteen read nonzero");

  a_rsv14_blocked: assert property (
    seq_gated_write |=> $stable(s.rsv14))
    else $error("bit fourteen changed without override");

  a_rsv_hi_blocked: assert property (
    seq_gated_write |=> $stable(s.rsv12_10) && $stable(s.selector))
    else $error("reserved field changed without override");

  a_override_applies: assert property (
    (reg_wr && reg_hit && cmd_override && s.phase == autoneg_adv_pkg::PH_NEG)
      |=> s.rsv12_10 == $past(reg_wdata[12:10]))
    else $error("override write not applied");

  a_fault_sets: assert property (
    local_link_fault |=> s.remote_fault ##1 (link_code_word[13] == $past(s.an_active)))
    else $error("local fault did not set remote fault");

  a_fault_clears: assert property (
    !local_link_fault |=> !s.remote_fault ##1 !link_code_word[13])
    else $error("remote fault not cleared");

  a_fault_in_word: assert property (
    (s.an_active && s.remote_fault) |=> link_code_word[13])
    else $error("remote fault missing from code word");

  a_rsv_hi_read_zero: assert property (
    reg_rdata_valid |-> reg_rdata[12:10] == 3'h0)
    else $error("reserved bits twelve to ten read nonzero");

  a_t4_zero: assert property (
    reg_rdata_valid |-> !reg_rdata[9] && !link_code_word[9])
    else $error("T4 ability seen as one");

  a_taf_blocked: assert property (
    seq_gated_write |=> $stable(s.technology_ability_field))
    else $error("ability bits changed without override");

  a_forced_idle: assert property (
    (s.phase == autoneg_adv_pkg::PH_IDLE && !autoneg_enable)
      |=> send_idle && !an_active && speed_100 == $past(rate_select))
    else $error("forced mode not idling on selects");

  a_an_default_ones: assert property (
    seq_init_an |-> s.technology_ability_field == 4'hf && s.selector == 5'h01)
    else $error("ability defaults not all ones");

  a_caps_fixed: assert property (
    !$fell(srst) |-> status_caps == 4'hf)
    else $error("status capabilities altered");

  a_selector_sent: assert property (
    seq_restart |=> link_code_word[4:0] == $past(s.selector))
    else $error("selector not carried into code word");

  a_word_frozen: assert property (
    !s.load_word |=> $stable(link_code_word[12:0]) && $stable(link_code_word[15:14]))
    else $error("code word changed without restart");

  a_np_written: assert property (
    (reg_wr && reg_hit && s.phase != autoneg_adv_pkg::PH_INIT) |=> s.next_page == $past(reg_wdata[15]))
    else $error("next page write not stored");

  a_rsv14_applies: assert property (
    (reg_wr && reg_hit && cmd_override && s.phase == autoneg_adv_pkg::PH_NEG)
      |=> s.rsv14 == $past(reg_wdata[14]))
    else $error("bit fourteen override write not applied");

  a_fault_readback: assert property (
    reg_rdata_valid |-> reg_rdata[13] == $past(s.remote_fault))
    else $error("remote fault not seen on read");

  a_taf_sent: assert property (
    seq_restart |=> link_code_word[8:5] == $past(s.technology_ability_field))
    else $error("abilities not carried into code word");

  a_init_selector: assert property (
    seq_init_an |=> link_code_word[4:0] == autoneg_adv_pkg::SEL_DEFAULT)
    else $error("selector default not sent after init");

  a_idle_to_neg: assert property (
    (s.phase == autoneg_adv_pkg::PH_IDLE && autoneg_enable)
      |=> s.phase == autoneg_adv_pkg::PH_NEG && s.load_word)
    else $error("negotiation start did not load code word");

endmodule : autoneg_advertisement_register

// file: test/sta_model.sv
// Management station model that drives the register bus of the block
`timescale 1ns/1ps
module sta_model (
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rdata_valid,
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  output logic an_restart
);
  // Idle bus at time zero
  initial
  begin
    reg_addr = 5'h1f;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    an_restart = 1'b0;
  end

  // One write; reserved bits go out as zero unless raw asks to break that
  task automatic wr_word(input logic [4:0] a, input logic [15:0] d, input bit raw);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = raw ? d : (d & 16'h81ff);
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    // Released lines must not keep showing the old value
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask : wr_word

  // One read; the answer must stand in the cycle after the strobe edge
  task automatic rd_word(input logic [4:0] a, output logic [15:0] d, output bit ok);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = (reg_rdata_valid === 1'b1);
    d = reg_rdata;
  endtask : rd_word

  // Restart pulse so newly written abilities get advertised
  task automatic restart();
    @(posedge clk_sys);
    #1;
    an_restart = 1'b1;
    @(posedge clk_sys);
    #1;
    an_restart = 1'b0;
  endtask : restart
endmodule : sta_model

// file: test/autoneg_advertisement_register_test.sv
// Self-checking testbench of the advertisement register
`timescale 1ns/1ps
module autoneg_advertisement_register_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cmd_override = 1'b0;
  logic autoneg_enable = 1'b1;
  logic rate_select = 1'b0;
  logic duplex_select = 1'b0;
  logic local_link_fault = 1'b0;
  logic hardware_software_mode_pin = 1'b0;
  logic [4:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic reg_rd;
  logic an_restart;
  logic [15:0] reg_rdata;
  logic reg_rdata_valid;
  logic [15:0] link_code_word;
  logic an_active;
  logic send_idle;
  logic speed_100;
  logic full_duplex;
  logic [3:0] status_caps;
  int error_cnt = 0;
  int num_checks = 0;

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  autoneg_advertisement_register dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid),
    .cmd_override(cmd_override),
    .autoneg_enable(autoneg_enable),
    .an_restart(an_restart),
    .rate_select(rate_select),
    .duplex_select(duplex_select),
    .local_link_fault(local_link_fault),
    .hardware_software_mode_pin(hardware_software_mode_pin),
    .link_code_word(link_code_word),
    .an_active(an_active),
    .send_idle(send_idle),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .status_caps(status_caps)
  );

  sta_model sta (
    .clk_sys(clk_sys),
    .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .an_restart(an_restart)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd_chk(input string n, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    sta.rd_word(5'h04, d, ok);
    chk({n, "_valid"}, 16'h0001, {15'h0000, ok});
    chk(n, e, d);
  endtask : rd_chk

  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Reset held 12 cycles, then init is left to finish
  task automatic do_reset();
    srst = 1'b1;
    tick(12);
    srst = 1'b0;
    tick(5);
  endtask : do_reset

  task automatic t_defaults();
    rd_chk("adv_after_reset", 16'h01e1);
    chk("status_caps", 16'h000f, {12'h000, status_caps});
    chk("word_init", 16'h01e1, link_code_word);
    chk("word_selector", 16'h0001, {11'h000, link_code_word[4:0]});
  endtask : t_defaults

  // Gated writes refused without override, taken with it, seen only after restart
  task automatic t_gating();
    sta.wr_word(5'h04, 16'hfe00, 1'b1);
    rd_chk("adv_gated", 16'h81e1);
    chk("word_before_restart", 16'h01e1, link_code_word);
    sta.restart();
    tick(1);
    chk("word_np_blocked_rsv", 16'h81e1, link_code_word);
    chk("word_next_page", 16'h0001, {15'h0000, link_code_word[15]});
    cmd_override = 1'b1;
    sta.wr_word(5'h04, 16'h5ea1, 1'b1);
    rd_chk("adv_rsv_read_zero", 16'h00a1);
    chk("word_held", 16'h81e1, link_code_word);
    sta.restart();
    tick(1);
    chk("word_override", 16'h5ca1, link_code_word);
    chk("word_rsv14", 16'h0001, {15'h0000, link_code_word[14]});
    chk("word_t4", 16'h0000, {15'h0000, link_code_word[9]});
    chk("word_abilities", 16'h0005, {12'h000, link_code_word[8:5]});
    sta.wr_word(5'h04, 16'h01e1, 1'b0);
    sta.restart();
    cmd_override = 1'b0;
    tick(1);
    chk("word_restored", 16'h01e1, link_code_word);
  endtask : t_gating

  task automatic t_fault();
    local_link_fault = 1'b1;
    tick(3);
    chk("word_fault", 16'h0001, {15'h0000, link_code_word[13]});
    rd_chk("adv_fault", 16'h21e1);
    local_link_fault = 1'b0;
    tick(3);
    rd_chk("adv_no_fault", 16'h01e1);
    chk("word_no_fault", 16'h01e1, link_code_word);
  endtask : t_fault

  // Forced mode for each rate and duplex pair, then back to negotiation
  task automatic t_forced();
    for (int i = 0; i < 4; i++)
    begin
      rate_select = i[1];
      duplex_select = i[0];
      autoneg_enable = 1'b0;
      tick(3);
      chk("forced_mode", {12'h000, 2'b10, i[1], i[0]},
          {12'h000, send_idle, an_active, speed_100, full_duplex});
    end
    autoneg_enable = 1'b1;
    tick(3);
    chk("renegotiate", 16'h0002, {14'h0000, an_active, send_idle});
  endtask : t_forced

  // Other addresses get no answer and change nothing
  task automatic t_unmapped();
    logic [15:0] d;
    bit ok;
    cmd_override = 1'b1;
    sta.wr_word(5'h05, 16'h0000, 1'b1);
    sta.rd_word(5'h05, d, ok);
    chk("unmapped_valid", 16'h0000, {15'h0000, ok});
    rd_chk("adv_untouched", 16'h01e1);
    cmd_override = 1'b0;
  endtask : t_unmapped

  // Hardware mode, negotiation off: defaults follow the selects
  task automatic t_pin_default();
    hardware_software_mode_pin = 1'b1;
    autoneg_enable = 1'b0;
    rate_select = 1'b1;
    duplex_select = 1'b0;
    do_reset();
    rd_chk("adv_pin_default", 16'h0081);
  endtask : t_pin_default

  // Watchdog against a hang
  initial
  begin
    #(40 * 3000);
    error_cnt++;
    summarize();
  end

  initial
  begin
    do_reset();
    t_defaults();
    t_gating();
    t_fault();
    t_forced();
    t_unmapped();
    t_pin_default();
    summarize();
  end
endmodule : autoneg_advertisement_register_test
